// ==== shared/boost_seq_pkg.sv ====
// Constants and types for the boost start-up and fault sequencer.
// Assumes a single 200 MHz system clock; all timing derives from it.
package boost_seq_pkg;
  localparam int unsigned MCLK_HZ = 200_000_000;
  localparam int unsigned OSC_HZ = 1_000_000;
  // Internal oscillator tick divider
  localparam int unsigned OSC_DIV = MCLK_HZ / OSC_HZ;
  // State times in microseconds
  localparam int unsigned SOFT_STATE_US = 2048;
  localparam int unsigned SWITCH_EN_US = 128;
  // Oscillator ticks per state, one tick per microsecond at 1 MHz
  localparam int unsigned SOFT_STATE_TICKS = SOFT_STATE_US * OSC_HZ / 1_000_000;
  localparam int unsigned SWITCH_EN_TICKS = SWITCH_EN_US * OSC_HZ / 1_000_000;
  // Sync detector: edge gap must be shorter than one 300 kHz period
  localparam int unsigned SYNC_MIN_HZ = 300_000;
  localparam int unsigned SYNC_MAX_GAP = MCLK_HZ / SYNC_MIN_HZ;
  // Minimum switch off-time in ns and its cycle count
  localparam int unsigned MIN_OFF_NS = 50;
  localparam int unsigned MIN_OFF_CYC = (MIN_OFF_NS * (MCLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned TICK_W = 12;
  localparam int unsigned GAP_W = 10;
  localparam int unsigned DIV_W = 8;
  // Current limit codes
  localparam logic [2:0] LIM_OFF = 3'h0;
  localparam logic [2:0] LIM_25 = 3'h1;
  localparam logic [2:0] LIM_50 = 3'h2;
  localparam logic [2:0] LIM_75 = 3'h3;
  localparam logic [2:0] LIM_100 = 3'h4;

  typedef enum logic [2:0] {
    ST_OFF = 3'b000,
    ST_INRUSH = 3'b001,
    ST_SWITCH_EN = 3'b010,
    ST_BOOST25 = 3'b011,
    ST_BOOST50 = 3'b100,
    ST_BOOST75 = 3'b101,
    ST_NORMAL = 3'b110,
    ST_FAULT_WAIT = 3'b111
  } seq_state_t;
endpackage

// ==== design/switch_timer.sv ====
// Switching period generator: internal 1 MHz oscillator or external sync falling edges.
// Assumes sync input is synchronous to i_mclk; handles detector, max duty and skip.
`timescale 1ns/1ps
`default_nettype none
module switch_timer (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_run,
  input wire logic i_sync_clock_input,
  input wire logic i_pwm_request,
  input wire logic i_skip,
  output logic o_osc_tick,
  output logic o_ext_sync,
  output logic o_switch_node_driver
);
  typedef struct packed {
    logic [boost_seq_pkg::DIV_W-1:0] div;
    logic [boost_seq_pkg::GAP_W-1:0] gap;
    logic sync_d;
    logic ext;
    logic tick;
    // Full gap width, so a slow sync period is not cut short
    logic [boost_seq_pkg::GAP_W-1:0] period;
    logic [boost_seq_pkg::GAP_W-1:0] phase;
    logic drv;
  } tmr_t;
  tmr_t s_r;
  tmr_t s_nxt;
  logic fall;
  logic start;
  always_comb begin
    s_nxt = s_r;
    fall = s_r.sync_d & ~i_sync_clock_input;
    s_nxt.sync_d = i_sync_clock_input;
    s_nxt.tick = 1'b0;
    // Free-running oscillator, also times the sequencer
    if (s_r.div == boost_seq_pkg::DIV_W'(boost_seq_pkg::OSC_DIV - 1)) begin
      s_nxt.div = '0;
      s_nxt.tick = 1'b1;
    end else begin
      s_nxt.div = s_r.div + 1'b1;
    end
    // Frequency detector: lock when falling edges come faster than 300 kHz
    if (fall) begin
      s_nxt.gap = '0;
      s_nxt.ext = (s_r.gap < boost_seq_pkg::GAP_W'(boost_seq_pkg::SYNC_MAX_GAP));
      s_nxt.period = s_r.gap;
    end else if (s_r.gap == boost_seq_pkg::GAP_W'(boost_seq_pkg::SYNC_MAX_GAP)) begin
      s_nxt.ext = 1'b0;
    end else begin
      s_nxt.gap = s_r.gap + 1'b1;
    end
    // Period start: sync falling edge when locked, else oscillator
    start = s_r.ext ? fall : s_r.tick;
    if (start) begin
      s_nxt.phase = '0;
    end else if (s_r.phase != '1) begin
      s_nxt.phase = s_r.phase + 1'b1;
    end
    // Max duty: driver forced off within min off-time before period end
    if (!i_run || i_skip) begin
      s_nxt.drv = 1'b0;
    end else if (start) begin
      s_nxt.drv = i_pwm_request;
    end else if (!i_pwm_request || (s_r.ext ?
        s_r.phase + boost_seq_pkg::GAP_W'(boost_seq_pkg::MIN_OFF_CYC) >= s_r.period :
        s_r.div >= boost_seq_pkg::DIV_W'(boost_seq_pkg::OSC_DIV - boost_seq_pkg::MIN_OFF_CYC)))
        begin
      s_nxt.drv = 1'b0;
    end
  end
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      s_r <= '0;
      s_r.sync_d <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end
  assign o_osc_tick = s_r.tick;
  assign o_ext_sync = s_r.ext;
  assign o_switch_node_driver = s_r.drv;
endmodule
`default_nettype wire

// ==== design/boost_startup_fault_sequencer.sv ====
// Top of the boost start-up sequencer with fault control.
// Assumes comparator inputs are synchronous, hysteresis levels given as separate flags.
`timescale 1ns/1ps
`default_nettype none
module boost_startup_fault_sequencer #(
  parameter int unsigned SOFT_TICKS = boost_seq_pkg::SOFT_STATE_TICKS,
  parameter int unsigned SWITCH_TICKS = boost_seq_pkg::SWITCH_EN_TICKS
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_enable_low_input,
  input wire logic i_sync_clock_input,
  input wire logic i_supply_below_off,
  input wire logic i_supply_above_on,
  input wire logic i_switch_overcurrent,
  input wire logic i_output_overvoltage,
  input wire logic i_output_recovered,
  input wire logic i_temp_shutdown,
  input wire logic i_temp_recovered,
  input wire logic i_feedback_input,
  input wire logic i_pwm_request,
  output logic o_switch_current_source,
  output logic o_input_disconnect_switch,
  output logic o_switch_node_driver,
  output logic [2:0] o_current_limit,
  output logic o_ext_sync,
  output logic o_active
);
  typedef struct packed {
    boost_seq_pkg::seq_state_t st;
    logic [boost_seq_pkg::TICK_W-1:0] ticks;
    logic uv_hold;
    logic ov_hold;
    logic ot_hold;
    logic src;
    logic sw;
    logic [2:0] lim;
  } seq_t;
  seq_t s_r;
  seq_t s_nxt;
  logic osc_tick;
  logic run;
  logic fault_off;
  logic restart_now;
  logic hold_any;
  logic done_soft;
  logic done_sw;

  switch_timer u_timer (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_run(run),
    .i_sync_clock_input(i_sync_clock_input),
    .i_pwm_request(i_pwm_request),
    .i_skip(i_feedback_input),
    .o_osc_tick(osc_tick),
    .o_ext_sync(o_ext_sync),
    .o_switch_node_driver(o_switch_node_driver)
  );

  always_comb begin
    s_nxt = s_r;
    fault_off = i_supply_below_off | i_output_overvoltage | i_temp_shutdown;
    restart_now = i_switch_overcurrent;
    done_soft = osc_tick &&
        (s_r.ticks == boost_seq_pkg::TICK_W'(SOFT_TICKS - 1));
    done_sw = osc_tick &&
        (s_r.ticks == boost_seq_pkg::TICK_W'(SWITCH_TICKS - 1));
    // Hold flags: a new fault wins over its own recovery
    if (i_supply_below_off) begin
      s_nxt.uv_hold = 1'b1;
    end else if (i_supply_above_on) begin
      s_nxt.uv_hold = 1'b0;
    end
    if (i_output_overvoltage) begin
      s_nxt.ov_hold = 1'b1;
    end else if (i_output_recovered) begin
      s_nxt.ov_hold = 1'b0;
    end
    if (i_temp_shutdown) begin
      s_nxt.ot_hold = 1'b1;
    end else if (i_temp_recovered) begin
      s_nxt.ot_hold = 1'b0;
    end
    hold_any = s_nxt.uv_hold | s_nxt.ov_hold | s_nxt.ot_hold;
    if (osc_tick) begin
      s_nxt.ticks = s_r.ticks + 1'b1;
    end
    if (i_enable_low_input) begin
      // Disabled: hold flags cleared too so re-enable starts clean
      s_nxt.st = boost_seq_pkg::ST_OFF;
      s_nxt.ticks = '0;
    end else if (fault_off || (s_r.st == boost_seq_pkg::ST_FAULT_WAIT && hold_any)) begin
      s_nxt.st = boost_seq_pkg::ST_FAULT_WAIT;
      s_nxt.ticks = '0;
    end else if (restart_now) begin
      s_nxt.st = boost_seq_pkg::ST_INRUSH;
      s_nxt.ticks = '0;
    end else begin
      unique case (s_r.st)
        boost_seq_pkg::ST_OFF, boost_seq_pkg::ST_FAULT_WAIT: begin
          s_nxt.st = hold_any ? boost_seq_pkg::ST_FAULT_WAIT : boost_seq_pkg::ST_INRUSH;
          s_nxt.ticks = '0;
        end
        boost_seq_pkg::ST_INRUSH: begin
          if (done_soft) begin
            s_nxt.st = boost_seq_pkg::ST_SWITCH_EN;
            s_nxt.ticks = '0;
          end
        end
        boost_seq_pkg::ST_SWITCH_EN: begin
          if (done_sw) begin
            s_nxt.st = boost_seq_pkg::ST_BOOST25;
            s_nxt.ticks = '0;
          end
        end
        boost_seq_pkg::ST_BOOST25: begin
          if (done_soft) begin
            s_nxt.st = boost_seq_pkg::ST_BOOST50;
            s_nxt.ticks = '0;
          end
        end
        boost_seq_pkg::ST_BOOST50: begin
          if (done_soft) begin
            s_nxt.st = boost_seq_pkg::ST_BOOST75;
            s_nxt.ticks = '0;
          end
        end
        boost_seq_pkg::ST_BOOST75: begin
          if (done_soft) begin
            s_nxt.st = boost_seq_pkg::ST_NORMAL;
            s_nxt.ticks = '0;
          end
        end
        boost_seq_pkg::ST_NORMAL: begin
          s_nxt.st = boost_seq_pkg::ST_NORMAL;
          s_nxt.ticks = '0;
        end
      endcase
    end
    if (i_enable_low_input) begin
      s_nxt.uv_hold = 1'b0;
      s_nxt.ov_hold = 1'b0;
      s_nxt.ot_hold = 1'b0;
    end
    // Registered outputs decoded from the next state
    s_nxt.src = (s_nxt.st == boost_seq_pkg::ST_INRUSH);
    s_nxt.sw = (s_nxt.st == boost_seq_pkg::ST_SWITCH_EN) ||
        (s_nxt.st == boost_seq_pkg::ST_BOOST25) || (s_nxt.st == boost_seq_pkg::ST_BOOST50) ||
        (s_nxt.st == boost_seq_pkg::ST_BOOST75) || (s_nxt.st == boost_seq_pkg::ST_NORMAL);
    unique case (s_nxt.st)
      boost_seq_pkg::ST_BOOST25: s_nxt.lim = boost_seq_pkg::LIM_25;
      boost_seq_pkg::ST_BOOST50: s_nxt.lim = boost_seq_pkg::LIM_50;
      boost_seq_pkg::ST_BOOST75: s_nxt.lim = boost_seq_pkg::LIM_75;
      boost_seq_pkg::ST_NORMAL: s_nxt.lim = boost_seq_pkg::LIM_100;
      default: s_nxt.lim = boost_seq_pkg::LIM_OFF;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // From the next state, so the driver drops in the same cycle as the limit
  assign run = (s_nxt.lim != boost_seq_pkg::LIM_OFF);
  assign o_switch_current_source = s_r.src;
  assign o_input_disconnect_switch = s_r.sw;
  assign o_current_limit = s_r.lim;
  assign o_active = (s_r.st != boost_seq_pkg::ST_OFF) &&
      (s_r.st != boost_seq_pkg::ST_FAULT_WAIT);
endmodule
`default_nettype wire

// ==== bench/boost_seq_asserts.sv ====
// Port checker for the boost start-up and fault sequencer.
// Assumes binding to the top module; a single clock domain.
`timescale 1ns/1ps
`default_nettype none
module boost_seq_asserts (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_enable_low_input,
  input wire logic i_supply_below_off,
  input wire logic i_supply_above_on,
  input wire logic i_switch_overcurrent,
  input wire logic i_output_overvoltage,
  input wire logic i_temp_shutdown,
  input wire logic o_switch_current_source,
  input wire logic o_input_disconnect_switch,
  input wire logic o_switch_node_driver,
  input wire logic [2:0] o_current_limit,
  input wire logic o_ext_sync,
  input wire logic o_active
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  wire logic hold_f = i_supply_below_off | i_output_overvoltage | i_temp_shutdown;
  // Two samples so a registered output stage is covered too
  property p_off;
    i_enable_low_input [*2] |=> !o_switch_current_source && !o_input_disconnect_switch
      && !o_switch_node_driver && o_current_limit == boost_seq_pkg::LIM_OFF;
  endproperty
  a_off: assert property (p_off) else $error("outputs not off while disabled");
  property p_start;
    $fell(i_enable_low_input) && !hold_f && !i_switch_overcurrent && i_supply_above_on
      |=> o_switch_current_source && o_active;
  endproperty
  a_start: assert property (p_start) else $error("no inrush after enable");
  property p_inrush;
    o_switch_current_source |-> !o_input_disconnect_switch
      && o_current_limit == boost_seq_pkg::LIM_OFF;
  endproperty
  a_inrush: assert property (p_inrush) else $error("inrush with switch on");
  property p_limit;
    o_current_limit != boost_seq_pkg::LIM_OFF |-> o_input_disconnect_switch;
  endproperty
  a_limit: assert property (p_limit) else $error("limit set, switch open");
  property p_step;
    $changed(o_current_limit) |-> o_current_limit == boost_seq_pkg::LIM_OFF
      || o_current_limit == $past(o_current_limit) + 3'h1;
  endproperty
  a_step: assert property (p_step) else $error("limit skipped a step");
  property p_drv;
    o_current_limit == boost_seq_pkg::LIM_OFF |-> !o_switch_node_driver;
  endproperty
  a_drv: assert property (p_drv) else $error("driver on with no limit");
  property p_hold;
    hold_f |=> !o_active && !o_input_disconnect_switch && !o_switch_node_driver;
  endproperty
  a_hold: assert property (p_hold) else $error("fault did not stop switches");
  property p_oc;
    i_switch_overcurrent && o_active && !hold_f && !i_enable_low_input
      |=> o_switch_current_source;
  endproperty
  a_oc: assert property (p_oc) else $error("overcurrent did not restart");
  property p_norm;
    o_current_limit == boost_seq_pkg::LIM_100 && !i_enable_low_input && !hold_f
      && !i_switch_overcurrent |=> o_current_limit == boost_seq_pkg::LIM_100;
  endproperty
  a_norm: assert property (p_norm) else $error("left normal without cause");
  c_start: cover property ($fell(i_enable_low_input) ##1 o_switch_current_source);
  c_sync: cover property ($rose(o_ext_sync));
  c_fault: cover property (hold_f ##1 !o_active);
endmodule
bind boost_startup_fault_sequencer boost_seq_asserts i_boost_seq_asserts (.i_mclk,
  .i_rst, .i_enable_low_input, .i_supply_below_off, .i_supply_above_on,
  .i_switch_overcurrent, .i_output_overvoltage, .i_temp_shutdown,
  .o_switch_current_source, .o_input_disconnect_switch, .o_switch_node_driver,
  .o_current_limit, .o_ext_sync, .o_active);
`default_nettype wire

// ==== bench/sync_host_model.sv ====
// Host model driving the sync clock pin.
// Assumes the same i_mclk; toggles every i_half cycles while running.
`timescale 1ns/1ps
`default_nettype none
module sync_host_model (
  input wire logic i_mclk,
  input wire logic i_run,
  input wire logic [9:0] i_half,
  output logic o_sync
);
  logic [9:0] cnt_r;
  // Idle level high selects the internal oscillator
  always @(posedge i_mclk) begin
    if (!i_run) begin
      cnt_r <= 10'h0;
      o_sync <= 1'h1;
    end else if (cnt_r + 10'h1 >= i_half) begin
      cnt_r <= 10'h0;
      o_sync <= ~o_sync;
    end else begin
      cnt_r <= cnt_r + 10'h1;
    end
  end
endmodule
`default_nettype wire

// ==== bench/tb_top.sv ====
// Testbench for the boost start-up and fault sequencer.
// Assumes a 200 MHz clock; state timers are shortened through parameters.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic i_mclk = 1'h0;
  logic i_rst = 1'h1;
  logic en_n = 1'h1, below_off = 1'h0, above_on = 1'h1, oc = 1'h0, ov = 1'h0;
  logic ov_rec = 1'h1, ot = 1'h0, ot_rec = 1'h1, fb = 1'h0, pwm_req = 1'h0;
  logic run = 1'h0, sync, src, disc, drv, ext, active;
  logic [9:0] half = 10'h64;
  logic [2:0] lim;
  int mismatches = 0, num_checks = 0, k;
  // Short state timers keep the whole sequence inside the run budget
  localparam int unsigned SOFT_T = 32'h4;
  localparam int unsigned SW_T = 32'h2;
  localparam logic [9:0] HALF = 10'ha7;
  always #2.5 i_mclk = ~i_mclk;
  sync_host_model i_sync_host_model (.i_mclk(i_mclk), .i_run(run), .i_half(half),
    .o_sync(sync));
  boost_startup_fault_sequencer #(.SOFT_TICKS(SOFT_T), .SWITCH_TICKS(SW_T))
    i_boost_startup_fault_sequencer (.i_mclk(i_mclk),
    .i_rst(i_rst), .i_enable_low_input(en_n), .i_sync_clock_input(sync),
    .i_supply_below_off(below_off), .i_supply_above_on(above_on),
    .i_switch_overcurrent(oc), .i_output_overvoltage(ov), .i_output_recovered(ov_rec),
    .i_temp_shutdown(ot), .i_temp_recovered(ot_rec), .i_feedback_input(fb),
    .i_pwm_request(pwm_req), .o_switch_current_source(src),
    .o_input_disconnect_switch(disc), .o_switch_node_driver(drv),
    .o_current_limit(lim), .o_ext_sync(ext), .o_active(active));
  task check(input logic [3:0] seen, input logic [3:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task step(input int n);
    repeat (n) @(posedge i_mclk);
  endtask
  task wait_src;
    for (k = 0; k < 8 && src !== 1'h1; k++) step(1);
    #1 check({active, src}, 4'h3);
    if (k == 8) test_done;
  endtask
  task wait_for(input logic [3:0] exp, input int t);
    int n;
    int lo;
    int hi;
    lo = int'((t - 1) * boost_seq_pkg::OSC_DIV);
    hi = int'(t * boost_seq_pkg::OSC_DIV);
    for (n = 0; n < 2000 && {disc, lim} !== exp; n++) step(1);
    check(n > lo && n <= hi, 4'h1);
    if (n == 2000) test_done;
  endtask
  task count_drv(input int len, output int c);
    c = 0;
    repeat (len) begin
      step(1);
      if (drv === 1'h1) c++;
    end
  endtask
  task set_k(input int sel, input logic f, input logic r);
    case (sel)
      0: begin below_off <= f; above_on <= r; end
      1: begin ov <= f; ov_rec <= r; end
      default: begin ot <= f; ot_rec <= r; end
    endcase
  endtask
  task t_start;
    @(posedge i_mclk) en_n <= 1'h0;
    pwm_req <= 1'h1;
    step(2);
    #1 check({active, src, disc, drv}, 4'hc);
    check(lim, 4'h0);
    step(400);
    #1 check({active, src, disc, drv}, 4'hc);
    @(posedge i_mclk) en_n <= 1'h1;
    step(3);
    #1 check({active, src, disc, drv}, 4'h0);
    $display("t_start done");
  endtask
  task t_fault(input int sel);
    @(posedge i_mclk) en_n <= 1'h0;
    step(3);
    @(posedge i_mclk) set_k(sel, 1'h1, 1'h0);
    step(3);
    #1 check({active, src, disc, drv}, 4'h0);
    @(posedge i_mclk) set_k(sel, 1'h0, 1'h0);
    step(5);
    #1 check({active, src}, 4'h0);
    @(posedge i_mclk) set_k(sel, 1'h0, 1'h1);
    wait_src;
    @(posedge i_mclk) en_n <= 1'h1;
    step(3);
    $display("t_fault %0d done", sel);
  endtask
  task t_boost;
    int c;
    @(posedge i_mclk) en_n <= 1'h0;
    wait_src;
    wait_for(4'h8, SOFT_T);
    wait_for(4'h9, SW_T);
    wait_for(4'ha, SOFT_T);
    wait_for(4'hb, SOFT_T);
    wait_for(4'hc, SOFT_T);
    step(200);
    count_drv(200, c);
    check(c == boost_seq_pkg::OSC_DIV - boost_seq_pkg::MIN_OFF_CYC, 4'h1);
    @(posedge i_mclk) fb <= 1'h1;
    step(2);
    count_drv(200, c);
    check(c == 0, 4'h1);
    @(posedge i_mclk) fb <= 1'h0;
    half <= HALF;
    run <= 1'h1;
    for (c = 0; c < 2000 && ext !== 1'h1; c++) step(1);
    #1 check({ext, lim}, 4'hc);
    if (c == 2000) test_done;
    step(400);
    count_drv(2 * HALF, c);
    check(c == 2 * HALF - boost_seq_pkg::MIN_OFF_CYC, 4'h1);
    // Reset in mid-run, with enable still low
    @(posedge i_mclk) i_rst <= 1'h1;
    step(2);
    #1 check({active, src, disc, drv}, 4'h0);
    check({ext, lim}, 4'h0);
    @(posedge i_mclk) i_rst <= 1'h0;
    run <= 1'h0;
    step(2);
    #1 check({active, src, disc, drv}, 4'hc);
    @(posedge i_mclk) en_n <= 1'h1;
    step(3);
    $display("t_boost done");
  endtask
  task t_oc;
    @(posedge i_mclk) en_n <= 1'h0;
    wait_src;
    wait_for(4'h8, SOFT_T);
    wait_for(4'h9, SW_T);
    // Part-way into the state, so a timer left uncleared would show
    step(450);
    @(posedge i_mclk) oc <= 1'h1;
    @(posedge i_mclk) oc <= 1'h0;
    #1 check({active, src, disc, drv}, 4'hc);
    check(lim, 4'h0);
    step(1);
    wait_for(4'h8, SOFT_T);
    @(posedge i_mclk) en_n <= 1'h1;
    step(3);
    $display("t_oc done");
  endtask
  task t_sync;
    @(posedge i_mclk) run <= 1'h1;
    for (k = 0; k < 2000 && ext !== 1'h1; k++) step(1);
    #1 check(ext, 4'h1);
    if (k == 2000) test_done;
    @(posedge i_mclk) run <= 1'h0;
    for (k = 0; k < 2000 && ext !== 1'h0; k++) step(1);
    #1 check(ext, 4'h0);
    if (k == 2000) test_done;
    @(posedge i_mclk) half <= 10'h1f4;
    run <= 1'h1;
    step(3000);
    #1 check(ext, 4'h0);
    @(posedge i_mclk) run <= 1'h0;
    $display("t_sync done");
  endtask
  initial begin
    step(5);
    i_rst <= 1'h0;
    step(2);
    #1 check({active, src, disc, drv}, 4'h0);
    t_start;
    for (int s = 0; s < 3; s++) t_fault(s);
    t_boost;
    t_oc;
    t_sync;
    test_done;
  end
endmodule
`default_nettype wire
